// ==== rtl/gdp_defines.svh ====
`ifndef GDP_DEFINES_SVH
`define GDP_DEFINES_SVH

// Register byte addresses on the plain register port.
`define GDP_ADDR_W       8
`define GDP_CFG_OFS      8'hac
`define GDP_STAT_OFS     8'hb0
`define GDP_MASK_OFS     8'hb4
`define GDP_LIVE_OFS     8'hb8

// Configuration reset value and the mask of software-writable bits.
`define GDP_CFG_RST      32'h10228100
`define GDP_CFG_WMASK    32'h8c0d3f03

// Event bit positions in the status and mask registers.
`define GDP_NEV          3
`define GDP_EV_OC        0
`define GDP_EV_OV        1
`define GDP_EV_OTW       2

// Overcurrent response codes.
`define GDP_OCM_LATCH    2'h0
`define GDP_OCM_RETRY    2'h1
`define GDP_OCM_REPORT   2'h2
`define GDP_OCM_IGNORE   2'h3

// Clock rate and the filter times in nanoseconds.
`define GDP_CLK_MHZ      40
`define GDP_DEG0_NS      200
`define GDP_DEG1_NS      600
`define GDP_DEG2_NS      1100
`define GDP_DEG3_NS      1600

// Retry waiting times in milliseconds.
`define GDP_WAIT0_MS     5
`define GDP_WAIT1_MS     500
`define GDP_CYC_PER_MS   40000

// Counter widths.
`define GDP_FILT_W       8
`define GDP_WAIT_W       25

`endif

// ==== rtl/gdp_pkg.sv ====
`include "gdp_defines.svh"
package gdp_pkg;

  // Field layout of the gate driver protection configuration word.
  typedef struct packed {
    logic       parity;
    logic [1:0] rsv30;
    logic       rsv28;
    logic [1:0] slew_rate;
    logic [1:0] rsv25;
    logic [3:0] rsv23;
    logic       overvoltage_threshold_sel;
    logic       overvoltage_protect_enable;
    logic       rsv17;
    logic       overtemp_warning_report_enable;
    logic [1:0] rsv15;
    logic [1:0] overcurrent_filter_time;
    logic       overcurrent_wait_time_sel;
    logic       overcurrent_threshold_sel;
    logic [1:0] overcurrent_response_sel;
    logic [5:0] rsv7;
    logic [1:0] sense_amp_fixed_gain;
  } gdp_cfg_t;

  // Analog comparator and sensor flags seen by the block.
  typedef struct packed {
    logic oc_16a;
    logic oc_24a;
    logic ov_32v;
    logic ov_20v;
    logic otw;
  } gdp_sense_t;

  // Overcurrent fault states.
  typedef enum logic [1:0] {
    GDP_OC_IDLE,
    GDP_OC_LATCH,
    GDP_OC_RETRY
  } gdp_oc_state_t;

  // Least whole number of clock cycles covering a time in ns.
  function automatic int unsigned gdp_ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * `GDP_CLK_MHZ + 999) / 1000;
    return (c == 0) ? 1 : c;
  endfunction : gdp_ns_to_cyc

endpackage : gdp_pkg

// ==== rtl/gdp_filter.sv ====
`timescale 1ns/1ps
`include "gdp_defines.svh"
module gdp_filter
  import gdp_pkg::*;
#(
  parameter int CW = `GDP_FILT_W
) (
  // Clock and reset.
  input  wire logic          mclk,
  input  wire logic          rst,
  // Raw condition and the cycles it must persist.
  input  wire logic          level,
  input  wire logic [CW-1:0] need,
  // Accepted condition.
  output logic               hit_q
);

  logic [CW-1:0] cnt_q;  // Cycles the condition has been present.

  // Count while the condition holds, restart as soon as it drops.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (!level) begin
      cnt_q <= '0;
    end else if (cnt_q != '1) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Accept once the condition has lasted the full filter time.
  // The extra top bit keeps a saturated count from wrapping to zero.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= level && (({1'b0, cnt_q} + 1'b1) >= {1'b0, need});
    end
  end

endmodule : gdp_filter

// ==== rtl/gdp_timer.sv ====
`timescale 1ns/1ps
`include "gdp_defines.svh"
module gdp_timer
  import gdp_pkg::*;
#(
  parameter int CW = `GDP_WAIT_W
) (
  // Clock and reset.
  input  wire logic          mclk,
  input  wire logic          rst,
  // Start pulse and the number of cycles to wait.
  input  wire logic          start,
  input  wire logic [CW-1:0] load,
  // One-cycle pulse when the wait has elapsed.
  output logic               done_q
);

  logic [CW-1:0] cnt_q;   // Cycles still to wait.
  logic          busy_q;  // High while a wait runs.

  // Count down the loaded wait and pulse done at its end.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        cnt_q  <= load;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q <= 1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

endmodule : gdp_timer

// ==== rtl/gdp_top.sv ====
// Overview of operation
// - Config word at 0xac, resets 0x10228100
// - Bits 27-26 choose driver slew rate
// - Bit 19 picks 32 V or 20 V
// - Bit 18 enables supply overvoltage protection
// - Bit 16 routes overtemp warning to fault pin
// - Bits 13-12 set overcurrent filter time
// - Bit 11 picks 5 ms or 500 ms wait
// - Bit 10 picks 16 A or 24 A trip
// - Mode 0 latches, mode 1 retries
// - Mode 2 reports only, mode 3 ignores
// - Bits 1-0 choose fixed sense gain
// - Auto gain enable overrides fixed gain
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "gdp_defines.svh"
module gdp_top
  import gdp_pkg::*;
#(
  parameter int unsigned WAIT0_CYC = `GDP_WAIT0_MS * `GDP_CYC_PER_MS,
  parameter int unsigned WAIT1_CYC = `GDP_WAIT1_MS * `GDP_CYC_PER_MS
) (
  // Clock and reset.
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // Register port.
  input  wire logic [`GDP_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata_q,
  // Sensor flags and the dynamic gain choice.
  input  wire gdp_sense_t             sense,
  input  wire logic                   sense_amp_auto_gain_enable,
  input  wire logic [1:0]             auto_gain,
  // Driver controls.
  output logic [1:0]                  slew_rate_q,
  output logic [1:0]                  sense_amp_gain_q,
  output logic                        drive_enable_q,
  // Open-drain fault pin and interrupt.
  output logic                        fault_out_n,
  output logic                        fault_out_n_oe,
  output logic                        irq
);

  // Filter lengths for the four codes.
  localparam int unsigned DEG0 = gdp_ns_to_cyc(`GDP_DEG0_NS);
  localparam int unsigned DEG1 = gdp_ns_to_cyc(`GDP_DEG1_NS);
  localparam int unsigned DEG2 = gdp_ns_to_cyc(`GDP_DEG2_NS);
  localparam int unsigned DEG3 = gdp_ns_to_cyc(`GDP_DEG3_NS);

  gdp_cfg_t              cfg_q;       // Configuration word.
  logic [`GDP_NEV-1:0]   stat_q;      // Sticky event flags.
  logic [`GDP_NEV-1:0]   mask_q;      // Interrupt mask.
  logic [`GDP_NEV-1:0]   ev;          // Event pulses this cycle.
  logic [`GDP_NEV-1:0]   clr;         // Flags cleared by software.
  gdp_oc_state_t         oc_state_q;  // Overcurrent fault state.
  logic                  oc_raw;      // Selected overcurrent flag.
  logic                  oc_hit;      // Filtered overcurrent.
  logic                  oc_hit_q;    // Delayed copy for edges.
  logic                  ov_raw;      // Selected overvoltage flag.
  logic                  ov_fault_q;  // Overvoltage fault active.
  logic                  otw_q;       // Delayed warning for edges.
  logic                  fault_q;     // Fault pin pulled low.
  logic [`GDP_FILT_W-1:0] deg_need;   // Filter length in cycles.
  logic [`GDP_WAIT_W-1:0] wait_load;  // Retry wait in cycles.
  logic                  wait_done;   // Retry wait elapsed.
  logic                  retry_go;    // Start of a retry wait.
  logic                  cfg_wr;      // Write to the config word.
  logic                  oc_rep;      // Overcurrent is reported.
  logic [31:0]           rd_mux;      // Read data before the flop.

  // Software write strobes for the config and status registers.
  assign cfg_wr = reg_wr && (reg_addr == `GDP_CFG_OFS);
  assign clr    = (reg_wr && (reg_addr == `GDP_STAT_OFS)) ?
                  reg_wdata[`GDP_NEV-1:0] : '0;

  // Store writable bits; reserved bits keep their reset values.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_q <= `GDP_CFG_RST;
    end else if (cfg_wr) begin
      // Parity is stored as written and read back unchanged.
      cfg_q <= (reg_wdata & `GDP_CFG_WMASK) |
               (`GDP_CFG_RST & ~`GDP_CFG_WMASK);
    end
  end

  // Interrupt mask register.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask_q <= '0;
    end else if (reg_wr && (reg_addr == `GDP_MASK_OFS)) begin
      mask_q <= reg_wdata[`GDP_NEV-1:0];
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      `GDP_CFG_OFS:  rd_mux = cfg_q;
      `GDP_STAT_OFS: rd_mux[`GDP_NEV-1:0] = stat_q;
      `GDP_MASK_OFS: rd_mux[`GDP_NEV-1:0] = mask_q;
      `GDP_LIVE_OFS: rd_mux[7:0] = {oc_state_q, oc_hit_q, ov_fault_q,
                                    fault_q, drive_enable_q,
                                    sense_amp_gain_q};
      default:       rd_mux = '0;
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= '0;
    end else begin
      reg_rdata_q <= reg_rd ? rd_mux : '0;
    end
  end

  // Slew rate output follows the stored field.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slew_rate_q <= '0;
    end else begin
      slew_rate_q <= cfg_q.slew_rate;
    end
  end

  // Effective sense gain: the dynamic choice wins when enabled.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sense_amp_gain_q <= '0;
    end else if (sense_amp_auto_gain_enable) begin
      sense_amp_gain_q <= auto_gain;
    end else begin
      sense_amp_gain_q <= cfg_q.sense_amp_fixed_gain;
    end
  end

  // Trip level picks which comparator counts as overcurrent.
  assign oc_raw = cfg_q.overcurrent_threshold_sel ?
                  sense.oc_24a : sense.oc_16a;

  // Filter length from the filter time code.
  always_comb begin
    unique case (cfg_q.overcurrent_filter_time)
      2'h0: deg_need = `GDP_FILT_W'(DEG0);
      2'h1: deg_need = `GDP_FILT_W'(DEG1);
      2'h2: deg_need = `GDP_FILT_W'(DEG2);
      2'h3: deg_need = `GDP_FILT_W'(DEG3);
    endcase
  end

  // Overcurrent is accepted only after it persists.
  gdp_filter #(
    .CW    (`GDP_FILT_W)
  ) u_filter (
    .mclk  (mclk),
    .rst   (rst),
    .level (oc_raw),
    .need  (deg_need),
    .hit_q (oc_hit)
  );

  // Retry wait length from the wait select bit.
  assign wait_load = cfg_q.overcurrent_wait_time_sel ?
                     `GDP_WAIT_W'(WAIT1_CYC) :
                     `GDP_WAIT_W'(WAIT0_CYC);

  // A retry wait starts when an accepted fault enters retry.
  assign retry_go = (oc_state_q == GDP_OC_IDLE) && oc_hit &&
                    (cfg_q.overcurrent_response_sel == `GDP_OCM_RETRY);

  // Timer that ends an automatically retrying fault.
  gdp_timer #(
    .CW     (`GDP_WAIT_W)
  ) u_timer (
    .mclk   (mclk),
    .rst    (rst),
    .start  (retry_go),
    .load   (wait_load),
    .done_q (wait_done)
  );

  // Overcurrent fault state machine.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      oc_state_q <= GDP_OC_IDLE;
    end else begin
      unique case (oc_state_q)
        GDP_OC_IDLE: begin
          // Report-only and ignore modes never leave idle.
          if (oc_hit && (cfg_q.overcurrent_response_sel ==
                         `GDP_OCM_LATCH)) begin
            oc_state_q <= GDP_OC_LATCH;
          end else if (retry_go) begin
            oc_state_q <= GDP_OC_RETRY;
          end
        end
        GDP_OC_LATCH: begin
          // Only a software clear of the flag releases a latch.
          if (clr[`GDP_EV_OC]) begin
            oc_state_q <= GDP_OC_IDLE;
          end
        end
        GDP_OC_RETRY: begin
          // Resume once the wait has run out.
          if (wait_done) begin
            oc_state_q <= GDP_OC_IDLE;
          end
        end
        default: oc_state_q <= GDP_OC_IDLE;
      endcase
    end
  end

  // Supply overvoltage acts only when protection is enabled.
  assign ov_raw = cfg_q.overvoltage_threshold_sel ?
                  sense.ov_20v : sense.ov_32v;

  // Overvoltage fault level.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ov_fault_q <= 1'b0;
    end else begin
      ov_fault_q <= cfg_q.overvoltage_protect_enable && ov_raw;
    end
  end

  // Delayed copies used to find rising edges.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      oc_hit_q <= 1'b0;
      otw_q    <= 1'b0;
    end else begin
      oc_hit_q <= oc_hit;
      otw_q    <= sense.otw;
    end
  end

  // Overcurrent is reported in every mode except ignore.
  assign oc_rep = (cfg_q.overcurrent_response_sel != `GDP_OCM_IGNORE);

  // Event pulses: each condition counts once per onset.
  always_comb begin
    ev = '0;
    ev[`GDP_EV_OC]  = oc_hit && !oc_hit_q && oc_rep;
    ev[`GDP_EV_OV]  = cfg_q.overvoltage_protect_enable && ov_raw &&
                      !ov_fault_q;
    ev[`GDP_EV_OTW] = sense.otw && !otw_q;
  end

  // Sticky flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr) | ev;
    end
  end

  // One level interrupt while any unmasked flag is set.
  assign irq = |(stat_q & mask_q);

  // Drivers run only while no acting fault is present.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      drive_enable_q <= 1'b0;
    end else begin
      drive_enable_q <= (oc_state_q == GDP_OC_IDLE) && !ov_fault_q;
    end
  end

  // Fault pin: acting faults, report-only overcurrent, warnings.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= (oc_state_q != GDP_OC_IDLE) || ov_fault_q ||
                 (oc_hit && (cfg_q.overcurrent_response_sel ==
                             `GDP_OCM_REPORT)) ||
                 (cfg_q.overtemp_warning_report_enable &&
                  sense.otw);
    end
  end

  // Open drain: the pin only ever pulls low.
  assign fault_out_n    = 1'b0;
  assign fault_out_n_oe = fault_q;

  // Checks run on the one clock and stop during reset.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_rsv_hold;
    (cfg_q & ~`GDP_CFG_WMASK) == (`GDP_CFG_RST & ~`GDP_CFG_WMASK);
  endproperty
  a_rsv_hold: assert property (p_rsv_hold)
    else $error("reserved config bits changed");

  property p_slew;
    cfg_wr |-> ##2 slew_rate_q == $past(reg_wdata[27:26], 2);
  endproperty
  a_slew: assert property (p_slew)
    else $error("slew output does not follow written field");

  property p_ov_lvl;
    cfg_q.overvoltage_protect_enable && cfg_q.overvoltage_threshold_sel
    && sense.ov_20v |=> ov_fault_q;
  endproperty
  a_ov_lvl: assert property (p_ov_lvl)
    else $error("20 V overvoltage not acted on");

  property p_ov_off;
    !cfg_q.overvoltage_protect_enable |=> !ov_fault_q;
  endproperty
  a_ov_off: assert property (p_ov_off)
    else $error("overvoltage acted on while disabled");

  property p_otw;
    cfg_q.overtemp_warning_report_enable && sense.otw |=> fault_q;
  endproperty
  a_otw: assert property (p_otw)
    else $error("warning not shown on fault pin");

  property p_deg0;
    (cfg_q.overcurrent_filter_time == 2'h0 && oc_raw) [*8] |=> oc_hit;
  endproperty
  a_deg0: assert property (p_deg0)
    else $error("overcurrent not accepted after 8 cycles");

  property p_retry_hold;
    $rose(oc_state_q == GDP_OC_RETRY) |->
      (oc_state_q == GDP_OC_RETRY) [*8];
  endproperty
  a_retry_hold: assert property (p_retry_hold)
    else $error("retry ended too early");

  property p_latch;
    oc_state_q == GDP_OC_LATCH && !clr[`GDP_EV_OC] |=>
      oc_state_q == GDP_OC_LATCH && !drive_enable_q;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latched fault released without clear");

  property p_ignore;
    cfg_q.overcurrent_response_sel == `GDP_OCM_IGNORE &&
    !stat_q[`GDP_EV_OC] |=> !stat_q[`GDP_EV_OC];
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("ignored overcurrent was reported");

  property p_gain;
    !sense_amp_auto_gain_enable |=>
      sense_amp_gain_q == $past(cfg_q.sense_amp_fixed_gain);
  endproperty
  a_gain: assert property (p_gain)
    else $error("fixed gain not applied");

  c_latch: cover property ($rose(oc_state_q == GDP_OC_LATCH));
  c_retry: cover property ($fell(oc_state_q == GDP_OC_RETRY));
  c_irq:   cover property ($rose(irq));

endmodule : gdp_top

// ==== testbench/gdp_top_tb_top.sv ====
`timescale 1ns/1ps
`include "gdp_defines.svh"
// Counts one comparison and reports a mismatch on a single line.
`define CHK(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) begin \
      bad_count++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
  end

module gdp_top_tb_top
  import gdp_pkg::*;
;
  // Short retry waits keep the run brief; expectations use these.
  localparam int unsigned W0  = 16;
  localparam int unsigned W1  = 32;
  // Reserved bits of the config word with writable fields cleared.
  localparam logic [31:0] RSV = 32'h10228000;

  // Clock, reset and register port.
  logic        mclk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata_q;
  // Sensor flags and gain choice.
  gdp_sense_t  sense;
  logic        auto_en;
  logic [1:0]  auto_gain;
  // Driver controls, fault pin and interrupt.
  logic [1:0]  slew_rate_q;
  logic [1:0]  sense_amp_gain_q;
  logic        drive_enable_q;
  logic        fault_out_n;
  logic        fault_out_n_oe;
  logic        irq;
  // Bookkeeping.
  int          bad_count;
  int          comparisons;
  int          cycles;
  int          n;
  int          nd[4] = '{8, 24, 44, 64};

  gdp_top #(.WAIT0_CYC(W0), .WAIT1_CYC(W1)) gdp_top_i (
    .mclk                      (mclk),
    .rst                       (rst),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_rdata_q               (reg_rdata_q),
    .sense                     (sense),
    .sense_amp_auto_gain_enable(auto_en),
    .auto_gain                 (auto_gain),
    .slew_rate_q               (slew_rate_q),
    .sense_amp_gain_q          (sense_amp_gain_q),
    .drive_enable_q            (drive_enable_q),
    .fault_out_n               (fault_out_n),
    .fault_out_n_oe            (fault_out_n_oe),
    .irq                       (irq)
  );

  // The clock runs at 40 MHz.
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // A hang is cut short well beyond the expected run length.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      $display("[ERR] timeout expected done seen hang");
      end_sim();
    end
  end

  // Builds a config word; fl is {ov level, ov enable, warn, wait, trip}.
  function automatic logic [31:0] cf(input logic [1:0] sl,
      input logic [1:0] gn, input logic [1:0] md, input logic [1:0] dg,
      input logic [4:0] fl);
    return RSV | (32'(sl) << 26) | (32'(fl[4]) << 19) | (32'(fl[3]) << 18)
         | (32'(fl[2]) << 16) | (32'(dg) << 12) | (32'(fl[1]) << 11)
         | (32'(fl[0]) << 10) | (32'(md) << 8) | 32'(gn);
  endfunction : cf

  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // One-cycle read strobe; data are taken in the following cycle only.
  task automatic chk_rd(input string nm, input logic [7:0] a,
      input logic [31:0] ex);
    logic [31:0] v;
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    v = reg_rdata_q;
    `CHK(nm, ex, v)
  endtask : chk_rd

  // Holds one sensor flag high for exactly len sampled edges.
  task automatic hold(input int b, input int len);
    @(posedge mclk);
    sense[b] <= 1'b1;
    repeat (len) @(posedge mclk);
    sense[b] <= 1'b0;
  endtask : hold

  // Drives the whole sensor word, then lets the outputs settle.
  task automatic put(input logic [4:0] v);
    @(posedge mclk);
    sense <= v;
    repeat (4) @(posedge mclk);
    #1;
  endtask : put

  // Counts cycles until drive enable shows v, giving up at lim.
  task automatic wait_de(input logic v, input int lim, output int c);
    c = 0;
    while (drive_enable_q !== v && c < lim) begin
      @(posedge mclk);
      #1;
      c++;
    end
  endtask : wait_de

  // Main sequence: reset, then one scenario per field.
  initial begin
    rst = 1'b1; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0;
    reg_rd = 1'b0; sense = '0; auto_en = 1'b0; auto_gain = '0;
    bad_count = 0; comparisons = 0; cycles = 0;
    repeat (8) @(posedge mclk);
    `CHK("de_in_reset", 1'b0, drive_enable_q)
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    `CHK("de_after_reset", 1'b1, drive_enable_q)
    `CHK("slew_reset", 2'h0, slew_rate_q)
    `CHK("gain_reset", 2'h0, sense_amp_gain_q)
    chk_rd("cfg_reset", `GDP_CFG_OFS, 32'h10228100);
    chk_rd("unmapped", 8'h00, 32'h0);
    // Reserved bits keep their value; parity is plain storage.
    wr(`GDP_CFG_OFS, 32'hffffffff);
    chk_rd("cfg_ones", `GDP_CFG_OFS, 32'h9c2fbf03);
    wr(`GDP_CFG_OFS, 32'h0);
    chk_rd("cfg_zero", `GDP_CFG_OFS, 32'h10228000);
    // Every slew and gain code, then the automatic gain override.
    for (int i = 0; i < 4; i++) begin
      wr(`GDP_CFG_OFS, cf(2'(i), 2'(3 - i), `GDP_OCM_RETRY, 2'h0, 5'h0));
      put(5'h0);
      `CHK("slew", 2'(i), slew_rate_q)
      `CHK("fixed_gain", 2'(3 - i), sense_amp_gain_q)
      @(posedge mclk);
      auto_gain <= 2'(i);
      auto_en   <= 1'b1;
      put(5'h0);
      `CHK("auto_gain", 2'(i), sense_amp_gain_q)
      @(posedge mclk);
      auto_en <= 1'b0;
    end
    // Filter times, one cycle short and exactly long, report-only mode.
    for (int k = 0; k < 4; k++) begin
      wr(`GDP_CFG_OFS, cf(2'h0, 2'h0, `GDP_OCM_REPORT, 2'(k), 5'h0));
      hold(4, nd[k] - 1);
      put(5'h0);
      chk_rd("oc_short", `GDP_STAT_OFS, 32'h0);
      hold(4, nd[k]);
      put(5'h0);
      chk_rd("oc_long", `GDP_STAT_OFS, 32'h1);
      wr(`GDP_STAT_OFS, 32'h1);
    end
    // Trip level selects which comparator counts.
    wr(`GDP_CFG_OFS, cf(2'h0, 2'h0, `GDP_OCM_REPORT, 2'h0, 5'h01));
    hold(4, 10);
    put(5'h0);
    chk_rd("lvl24_low", `GDP_STAT_OFS, 32'h0);
    hold(3, 10);
    put(5'h0);
    chk_rd("lvl24_high", `GDP_STAT_OFS, 32'h1);
    wr(`GDP_STAT_OFS, 32'h1);
    wr(`GDP_CFG_OFS, cf(2'h0, 2'h0, `GDP_OCM_REPORT, 2'h0, 5'h0));
    hold(3, 10);
    put(5'h0);
    chk_rd("lvl16_high", `GDP_STAT_OFS, 32'h0);
    // Report only: pin stays low through a long overcurrent, drivers run.
    put(5'h10);
    repeat (300) @(posedge mclk);
    #1;
    `CHK("rep_de", 1'b1, drive_enable_q)
    `CHK("rep_pin", 1'b1, fault_out_n_oe)
    put(5'h0);
    `CHK("rep_pin_off", 1'b0, fault_out_n_oe)
    wr(`GDP_STAT_OFS, 32'h1);
    // Ignore mode: neither reported nor acted upon.
    wr(`GDP_CFG_OFS, cf(2'h0, 2'h0, `GDP_OCM_IGNORE, 2'h0, 5'h0));
    hold(4, 20);
    put(5'h0);
    `CHK("ign_de", 1'b1, drive_enable_q)
    chk_rd("ign_stat", `GDP_STAT_OFS, 32'h0);
    // Automatic retry with both waiting times.
    for (int w = 0; w < 2; w++) begin
      wr(`GDP_CFG_OFS, cf(2'h0, 2'h0, `GDP_OCM_RETRY, 2'h0,
                          {3'h0, 1'(w), 1'b0}));
      hold(4, 8);
      wait_de(1'b0, 10, n);
      `CHK("retry_trip", 1'b0, drive_enable_q)
      wait_de(1'b1, 60, n);
      n = n - int'(w ? W1 : W0);
      `CHK("retry_wait", 1'b1, n >= 0 && n <= 5)
      wr(`GDP_STAT_OFS, 32'h1);
    end
    // Latched fault holds well past any retry time until cleared.
    wr(`GDP_CFG_OFS, cf(2'h0, 2'h0, `GDP_OCM_LATCH, 2'h0, 5'h0));
    hold(4, 8);
    wait_de(1'b0, 10, n);
    repeat (80) @(posedge mclk);
    #1;
    `CHK("latch_de", 1'b0, drive_enable_q)
    `CHK("latch_pin", 1'b1, fault_out_n_oe)
    wr(`GDP_STAT_OFS, 32'h1);
    wait_de(1'b1, 8, n);
    `CHK("latch_clear", 1'b1, drive_enable_q)
    // Overvoltage disabled, then the 32 V level, with the interrupt.
    wr(`GDP_CFG_OFS, cf(2'h0, 2'h0, `GDP_OCM_RETRY, 2'h0, 5'h0));
    put(5'h06);
    `CHK("ov_off_de", 1'b1, drive_enable_q)
    chk_rd("ov_off_stat", `GDP_STAT_OFS, 32'h0);
    put(5'h0);
    wr(`GDP_CFG_OFS, cf(2'h0, 2'h0, `GDP_OCM_RETRY, 2'h0, 5'h08));
    put(5'h02);
    `CHK("ov32_low", 1'b1, drive_enable_q)
    put(5'h06);
    `CHK("ov32_high", 1'b0, drive_enable_q)
    chk_rd("ov_stat", `GDP_STAT_OFS, 32'h2);
    `CHK("irq_masked", 1'b0, irq)
    wr(`GDP_MASK_OFS, 32'h2);
    put(5'h0);
    `CHK("irq_on", 1'b1, irq)
    `CHK("ov_gone_de", 1'b1, drive_enable_q)
    wr(`GDP_STAT_OFS, 32'h2);
    put(5'h0);
    `CHK("irq_off", 1'b0, irq)
    // The 20 V level trips on the lower comparator.
    wr(`GDP_CFG_OFS, cf(2'h0, 2'h0, `GDP_OCM_RETRY, 2'h0, 5'h18));
    put(5'h02);
    `CHK("ov20", 1'b0, drive_enable_q)
    put(5'h0);
    wr(`GDP_STAT_OFS, 32'h2);
    // Warning reaches the pin only when enabled.
    wr(`GDP_CFG_OFS, cf(2'h0, 2'h0, `GDP_OCM_RETRY, 2'h0, 5'h0));
    put(5'h01);
    `CHK("otw_hidden", 1'b0, fault_out_n_oe)
    chk_rd("otw_stat", `GDP_STAT_OFS, 32'h4);
    wr(`GDP_CFG_OFS, cf(2'h0, 2'h0, `GDP_OCM_RETRY, 2'h0, 5'h04));
    put(5'h01);
    `CHK("otw_shown", 1'b1, fault_out_n_oe)
    `CHK("pin_level", 1'b0, fault_out_n)
    put(5'h0);
    `CHK("otw_gone", 1'b0, fault_out_n_oe)
    end_sim();
  end
endmodule : gdp_top_tb_top
